// ---- fcp_regs.svh ----
/*
 * register offsets, field positions, reset values and counts of the
 * five channel pwm block.
 * assumes byte offsets are used directly as ahb byte addresses.
 */
`ifndef FCP_REGS_SVH
`define FCP_REGS_SVH

// register byte offsets (word index times four)
`define FCP_OFF_CTRL_UPPER   8'h38
`define FCP_OFF_DUTY_FOUR    8'h3C
`define FCP_OFF_PERIOD       8'h64
`define FCP_OFF_DUTY_ZERO    8'h68
`define FCP_OFF_DUTY_ONE     8'h6C
`define FCP_OFF_CTRL_LOWER   8'h70
`define FCP_OFF_DUTY_TWO     8'h74
`define FCP_OFF_DUTY_THREE   8'h78

// printed register indices
`define FCP_IDX_CTRL_UPPER   8'hCE
`define FCP_IDX_DUTY_FOUR    8'hCF
`define FCP_IDX_PERIOD       8'hD9
`define FCP_IDX_DUTY_ZERO    8'hDA
`define FCP_IDX_DUTY_ONE     8'hDB
`define FCP_IDX_CTRL_LOWER   8'hDC
`define FCP_IDX_DUTY_TWO     8'hDD
`define FCP_IDX_DUTY_THREE   8'hDE

// control lower field positions
`define FCP_CH0_RUN_BIT      0
`define FCP_CH1_RUN_BIT      1
`define FCP_CH0_SEL_BIT      2
`define FCP_CH1_SEL_BIT      3
`define FCP_CH2_RUN_BIT      4
`define FCP_CH3_RUN_BIT      5
`define FCP_CH2_SEL_BIT      6
`define FCP_CH3_SEL_BIT      7
// control upper field positions
`define FCP_CH4_RUN_BIT      0
`define FCP_CH4_SEL_BIT      2
`define FCP_CTRL_UPPER_MASK  8'h05

`define FCP_RESET_BYTE       8'h00
`define FCP_CNT_LAST         8'hFE
`define FCP_CNT_ZERO         8'h00
`define FCP_PRE_ZERO         8'h00

`endif

// ---- fcp_pkg.sv ----
/*
 * types of the five channel pwm block.
 * assumes fcp_regs.svh holds the numeric constants.
 */
package fcp_pkg;
    typedef logic [7:0] fcp_byte_t;

    // ahb-lite slave request group
    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic        hready;
        logic [31:0] hwdata;
    } fcp_ahb_req_t;

    // ahb-lite slave answer group
    typedef struct packed {
        logic [31:0] hrdata;
        logic        hreadyout;
        logic        hresp;
    } fcp_ahb_rsp_t;

    // pins toward port one bits three to seven
    typedef struct packed {
        logic [4:0] pin_output_select;
        logic [4:0] pwm_level;
    } fcp_pins_t;
endpackage : fcp_pkg

// ---- fcp_top.sv ----
/*
 * five channel pwm with ahb-lite register slave.
 * assumes one ahb-lite master on core_clk, a port mux outside that
 * takes pwm_level where pin_output_select is set, and sys_rst sync.
 */
//
// Overview of operation
// - one shared 8-bit prescaler clocks counter
// - prescaler divides by period plus one
// - output high only when duty exceeds counter
// - duty 00H low, FFH high constantly
// - new duty value compared immediately
// - run bits start and stop channels
// - pin follows pwm only when selected
// - channels zero to four on port bits three-seven
// - lower control register bit layout
// - upper control register, bits two and zero
// - six read/write byte registers, period and duties
// - reset clears all registers to zero
`timescale 1ns/10ps
`default_nettype none
`include "fcp_regs.svh"

module fcp_top (
    input  wire logic                 core_clk,
    input  wire logic                 sys_rst,
    input  wire fcp_pkg::fcp_ahb_req_t ahb_req,
    output var  fcp_pkg::fcp_ahb_rsp_t ahb_rsp,
    output var  fcp_pkg::fcp_pins_t    pins
);
    import fcp_pkg::*;

    fcp_byte_t   period_prescale_r;
    fcp_byte_t   control_lower_channels_r;
    fcp_byte_t   control_upper_channel_r;
    fcp_byte_t   duty_r [0:4];
    fcp_byte_t   pre_cnt_r;
    fcp_byte_t   pwm_cnt_r;
    logic [4:0]  channel_run;
    logic [4:0]  sel_bits;
    logic [4:0]  pwm_int;
    logic        any_run;
    logic        tick;
    logic        wr_pend_r;
    logic [7:0]  wr_addr_r;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic        take;
    fcp_byte_t   wbyte;

    // bus slave is always ready and never errors
    assign ahb_rsp.hreadyout = 1'b1;
    assign ahb_rsp.hresp     = 1'b0;
    assign ahb_rsp.hrdata    = rdata_r;
    assign take  = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready;
    assign wbyte = ahb_req.hwdata[7:0];

    // capture write address phase for the following data phase
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end else begin
            wr_pend_r <= take && ahb_req.hwrite;
            wr_addr_r <= ahb_req.haddr[7:0];
        end
    end

    // read mux, reserved bits and unmapped offsets read zero
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (ahb_req.haddr[7:0] == `FCP_OFF_CTRL_UPPER) begin
            rdata_nxt[7:0] = control_upper_channel_r;
        end else if (ahb_req.haddr[7:0] == `FCP_OFF_DUTY_FOUR) begin
            rdata_nxt[7:0] = duty_r[4];
        end else if (ahb_req.haddr[7:0] == `FCP_OFF_PERIOD) begin
            rdata_nxt[7:0] = period_prescale_r;
        end else if (ahb_req.haddr[7:0] == `FCP_OFF_DUTY_ZERO) begin
            rdata_nxt[7:0] = duty_r[0];
        end else if (ahb_req.haddr[7:0] == `FCP_OFF_DUTY_ONE) begin
            rdata_nxt[7:0] = duty_r[1];
        end else if (ahb_req.haddr[7:0] == `FCP_OFF_CTRL_LOWER) begin
            rdata_nxt[7:0] = control_lower_channels_r;
        end else if (ahb_req.haddr[7:0] == `FCP_OFF_DUTY_TWO) begin
            rdata_nxt[7:0] = duty_r[2];
        end else if (ahb_req.haddr[7:0] == `FCP_OFF_DUTY_THREE) begin
            rdata_nxt[7:0] = duty_r[3];
        end
    end

    // read data registered at the address phase edge
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rdata_r <= 32'h0000_0000;
        end else if (take && !ahb_req.hwrite) begin
            rdata_r <= rdata_nxt;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            period_prescale_r <= `FCP_RESET_BYTE;
        end else if (wr_pend_r && wr_addr_r == `FCP_OFF_PERIOD) begin
            period_prescale_r <= wbyte;
        end
    end

    // lower control register, all bits writable
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            control_lower_channels_r <= `FCP_RESET_BYTE;
        end else if (wr_pend_r && wr_addr_r == `FCP_OFF_CTRL_LOWER) begin
            control_lower_channels_r <= wbyte;
        end
    end

    // upper control, reserved bits held at zero
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            control_upper_channel_r <= `FCP_RESET_BYTE;
        end else if (wr_pend_r && wr_addr_r == `FCP_OFF_CTRL_UPPER) begin
            control_upper_channel_r <= wbyte & `FCP_CTRL_UPPER_MASK;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            for (int i = 0; i < 5; i++) begin
                duty_r[i] <= `FCP_RESET_BYTE;
            end
        end else if (wr_pend_r) begin
            if (wr_addr_r == `FCP_OFF_DUTY_ZERO) begin
                duty_r[0] <= wbyte;
            end else if (wr_addr_r == `FCP_OFF_DUTY_ONE) begin
                duty_r[1] <= wbyte;
            end else if (wr_addr_r == `FCP_OFF_DUTY_TWO) begin
                duty_r[2] <= wbyte;
            end else if (wr_addr_r == `FCP_OFF_DUTY_THREE) begin
                duty_r[3] <= wbyte;
            end else if (wr_addr_r == `FCP_OFF_DUTY_FOUR) begin
                duty_r[4] <= wbyte;
            end
        end
    end

    // run and select bits per channel
    assign channel_run = {control_upper_channel_r[`FCP_CH4_RUN_BIT],
                          control_lower_channels_r[`FCP_CH3_RUN_BIT],
                          control_lower_channels_r[`FCP_CH2_RUN_BIT],
                          control_lower_channels_r[`FCP_CH1_RUN_BIT],
                          control_lower_channels_r[`FCP_CH0_RUN_BIT]};
    assign sel_bits    = {control_upper_channel_r[`FCP_CH4_SEL_BIT],
                          control_lower_channels_r[`FCP_CH3_SEL_BIT],
                          control_lower_channels_r[`FCP_CH2_SEL_BIT],
                          control_lower_channels_r[`FCP_CH1_SEL_BIT],
                          control_lower_channels_r[`FCP_CH0_SEL_BIT]};
    assign any_run     = |channel_run;

    // shared prescaler, tick every period plus one cycles
    assign tick = (pre_cnt_r >= period_prescale_r);
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pre_cnt_r <= `FCP_PRE_ZERO;
        end else if (!any_run || tick) begin
            pre_cnt_r <= `FCP_PRE_ZERO;
        end else begin
            pre_cnt_r <= pre_cnt_r + 8'h01;
        end
    end

    // counter wraps at 254, frozen when nothing runs
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pwm_cnt_r <= `FCP_CNT_ZERO;
        end else if (any_run && tick) begin
            if (pwm_cnt_r >= `FCP_CNT_LAST) begin
                pwm_cnt_r <= `FCP_CNT_ZERO;
            end else begin
                pwm_cnt_r <= pwm_cnt_r + 8'h01;
            end
        end
    end

    // per channel compare; duty read live, so a write acts at once
    // and 00H never exceeds, FFH always exceeds the counter
    genvar ch;
    generate
        for (ch = 0; ch < 5; ch++) begin : g_ch
            always_ff @(posedge core_clk) begin
                if (sys_rst) begin
                    pwm_int[ch] <= 1'b0;
                end else begin
                    pwm_int[ch] <= channel_run[ch] && (duty_r[ch] > pwm_cnt_r);
                end
            end
        end
    endgenerate

    // bit n maps to port one bit n plus three
    assign pins.pin_output_select = sel_bits;
    assign pins.pwm_level         = pwm_int & sel_bits;

endmodule // fcp_top

`default_nettype wire

// ---- fcp_chk.sv ----
/* fcp_chk: port assertions for the five channel pwm block.
   assumes the bind below and single ahb-lite transfers. */
`timescale 1ns/10ps
`default_nettype none
`include "fcp_regs.svh"
module fcp_chk (
    input wire logic                  core_clk,
    input wire logic                  sys_rst,
    input wire fcp_pkg::fcp_ahb_req_t ahb_req,
    input wire fcp_pkg::fcp_ahb_rsp_t ahb_rsp,
    input wire fcp_pkg::fcp_pins_t    pins
);
    import fcp_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // a read address phase taken this edge
    wire logic rd_take = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready && !ahb_req.hwrite;
    // write address phase to one offset
    sequence s_wr(logic [7:0] a);
        ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready && ahb_req.hwrite
            && ahb_req.haddr[7:0] == a;
    endsequence
    a_ready_high: assert property (ahb_rsp.hreadyout) else $error("hreadyout low");
    a_resp_okay: assert property (!ahb_rsp.hresp) else $error("hresp not okay");
    a_rdata_byte: assert property (ahb_rsp.hrdata[31:8] == 24'h0)
        else $error("hrdata upper bits set");
    a_level_gated: assert property ((pins.pwm_level & ~pins.pin_output_select) == 5'h00)
        else $error("pwm level on unselected pin");
    a_reset_clear: assert property ($past(sys_rst) |-> pins == '0 && ahb_rsp.hrdata == 32'h0)
        else $error("outputs not cleared by reset");
    a_rdata_stands: assert property (!$past(rd_take) |-> $stable(ahb_rsp.hrdata))
        else $error("hrdata changed without read");
    a_sel_lower: assert property (s_wr(`FCP_OFF_CTRL_LOWER) |-> ##2
        pins.pin_output_select[3:0] == {$past(ahb_req.hwdata[7]), $past(ahb_req.hwdata[6]),
        $past(ahb_req.hwdata[3]), $past(ahb_req.hwdata[2])}) else $error("lower select wrong");
    a_sel_upper: assert property (s_wr(`FCP_OFF_CTRL_UPPER) |-> ##2
        pins.pin_output_select[4] == $past(ahb_req.hwdata[2])) else $error("upper select wrong");
endmodule // fcp_chk
bind fcp_top fcp_chk u_chk (.core_clk(core_clk), .sys_rst(sys_rst), .ahb_req(ahb_req),
    .ahb_rsp(ahb_rsp), .pins(pins));
`default_nettype wire

// ---- five_channel_pwm_bench.sv ----
/* five_channel_pwm_bench: self-checking bench of fcp_top.
   assumes one ahb-lite slave whose hreadyout is the bus hready. */
`timescale 1ns/10ps
`default_nettype none
module five_channel_pwm_bench;
    import fcp_pkg::*;
    logic         core_clk  = 1'b0;
    logic         sys_rst   = 1'b1;
    logic         hsel      = 1'b0;
    logic         hwrite    = 1'b0;
    logic [7:0]   haddr     = 8'h00;
    logic [1:0]   htrans    = 2'b00;
    logic [31:0]  hwdata    = 32'h0;
    logic [31:0]  rd;
    int           err_total = 0;
    int           tests_run = 0;
    fcp_ahb_req_t ahb_req;
    fcp_ahb_rsp_t ahb_rsp;
    fcp_pins_t    pins;
    // byte offsets of the eight registers, control upper first
    logic [7:0]   offs [8]  = '{8'h38, 8'h3C, 8'h64, 8'h68, 8'h6C, 8'h70, 8'h74, 8'h78};
    // one slave, so hready is its own hreadyout
    assign ahb_req = '{hsel, {24'h0, haddr}, htrans, hwrite, 3'h2, ahb_rsp.hreadyout, hwdata};
    always #5 core_clk = ~core_clk;
    fcp_top dut (.core_clk(core_clk), .sys_rst(sys_rst), .ahb_req(ahb_req),
        .ahb_rsp(ahb_rsp), .pins(pins));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s exp %h got %h", what, exp, got);
        end
    endtask
    // single transfer; entry edge leaves one idle cycle so reads never race writes
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge core_clk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge core_clk); while (ahb_rsp.hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge core_clk); while (ahb_rsp.hreadyout !== 1'b1);
        rd = ahb_rsp.hrdata;
    endtask
    // high cycles per channel over a window
    task automatic count(input int n, output int hi [5]);
        hi = '{default: 0};
        repeat (n) begin
            @(negedge core_clk);
            for (int k = 0; k < 5; k++) hi[k] += int'(pins.pwm_level[k] === 1'b1);
        end
    endtask
    task automatic t_regs();
        for (int i = 0; i < 8; i++) begin
            bus(1'b0, offs[i], 32'h0);
            chk("reset value", 32'h0, rd);
            bus(1'b1, offs[i], 32'hFFFF_FFA5 + i);
        end
        bus(1'b1, 8'h40, 32'hFF);
        bus(1'b0, 8'h40, 32'h0);
        chk("unmapped read", 32'h0, rd);
        for (int i = 0; i < 8; i++) begin
            bus(1'b0, offs[i], 32'h0);
            chk("read back", (i == 0) ? 32'h05 : 32'hA5 + i, rd);
        end
        chk("pin select", 32'h1A, {27'h0, pins.pin_output_select});
    endtask
    task automatic t_wave();
        int hi [5];
        int ex [5] = '{0, 510, 256, 0, 0};
        // period 1 divides by two; ch3 selected but stopped, ch4 running unselected
        bus(1'b1, 8'h64, 32'h01);
        bus(1'b1, 8'h68, 32'h00);
        bus(1'b1, 8'h6C, 32'hFF);
        bus(1'b1, 8'h74, 32'h80);
        bus(1'b1, 8'h78, 32'hC0);
        bus(1'b1, 8'h3C, 32'h40);
        bus(1'b1, 8'h70, 32'hDF);
        bus(1'b1, 8'h38, 32'h01);
        count(510, hi);
        for (int k = 0; k < 5; k++) chk("high cycles", ex[k], hi[k]);
        bus(1'b1, 8'h38, 32'h05);
        count(510, hi);
        chk("ch4 high cycles", 32'd128, hi[4]);
    endtask
    task automatic t_live();
        bus(1'b1, 8'h74, 32'h00);
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        chk("duty cleared", 32'h0, {31'h0, pins.pwm_level[2]});
        bus(1'b1, 8'h74, 32'hFF);
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        chk("duty full", 32'h1, {31'h0, pins.pwm_level[2]});
    endtask
    task automatic end_sim();
        if (err_total == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge core_clk);
        err_total++;
        end_sim();
    end
    initial begin
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_regs();
        t_wave();
        t_live();
        end_sim();
    end
endmodule // five_channel_pwm_bench
`default_nettype wire
